// File: hdl/ccr_clock_run_request.sv
// clock run request logic: asks a stopped bus clock to restart for pending events
`timescale 1ns/10ps
`default_nettype none

module ccr_clock_run_request (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // configuration
    input wire logic irq_clock_run_enable_i,
    // internal event sources
    input wire ccr_pkg::ccr_src_t src_i,
    // host-side delivery completion strobes
    input wire ccr_pkg::ccr_done_t done_i,
    // bus clock, sampled as an ordinary input
    input wire logic pci_clk_i,
    // shared open-drain clock run line
    input wire logic clkrun_n_i,
    output logic clkrun_n_o,
    output logic clkrun_n_oe_o,
    // status
    output logic clock_restart_event_o,
    output logic restart_pending_o,
    output logic line_stopped_o
);
    import ccr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////////

    logic line_sync;
    logic pci_edge;

    logic [CCR_IRQ_W-1:0] irq_last_reg;
    logic [CCR_DRQ_W-1:0] drq_last_reg;
    logic [CCR_IRQ_W-1:0] irq_change;
    logic [CCR_DRQ_W-1:0] drq_assert;
    logic clock_restart_event;

    logic pending_reg;
    logic pending_next;
    logic delivered;

    logic [CCR_CNT_W-1:0] high_cnt_reg;
    logic [CCR_CNT_W-1:0] high_cnt_next;
    logic high_ok;

    logic [CCR_CNT_W-1:0] hold_cnt_reg;
    logic [CCR_CNT_W-1:0] hold_cnt_next;

    ccr_state_t state_reg;
    ccr_state_t state_next;

    logic start_drive;
    logic drive_done;

    logic drive_level_reg;
    logic oe_reg;
    logic oe_next;
    logic event_reg;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers for the line and the bus clock
    ////////////////////////////////////////////////////////////////////////////

    // line state, resync before any decision
    ccr_sync u_line_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i (rst_i),
        .async_i (clkrun_n_i),
        .sync_o (line_sync),
        .rise_o ()
    );

    // bus clock rising edges as one-cycle enables
    ccr_sync u_pci_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i (rst_i),
        .async_i (pci_clk_i),
        .sync_o (),
        .rise_o (pci_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // restart event detection
    ////////////////////////////////////////////////////////////////////////////

    // remember previous source levels every system cycle
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            irq_last_reg <= '0;
            drq_last_reg <= '0;
        end else begin
            irq_last_reg <= src_i.irq;
            drq_last_reg <= src_i.drq;
        end
    end

    // either-edge change per interrupt line
    genvar gi;
    generate
        for (gi = 0; gi < CCR_IRQ_W; gi++) begin : g_irq
            assign irq_change[gi] = src_i.irq[gi] ^ irq_last_reg[gi];
        end
    endgenerate

    // assertion edge per dma request line
    genvar gd;
    generate
        for (gd = 0; gd < CCR_DRQ_W; gd++) begin : g_drq
            assign drq_assert[gd] = src_i.drq[gd] & ~drq_last_reg[gd];
        end
    endgenerate

    // any event counts only while the function is enabled
    assign clock_restart_event = irq_clock_run_enable_i
                                 & ((|irq_change) | (|drq_assert));

    ////////////////////////////////////////////////////////////////////////////
    // pending event latch
    ////////////////////////////////////////////////////////////////////////////

    // a finished serial irq or dma cycle delivers the event
    assign delivered = done_i.sirq_done | done_i.dma_done;

    // new event wins over a same-cycle delivery
    always_comb begin
        pending_next = pending_reg;
        if (!irq_clock_run_enable_i) begin
            pending_next = 1'h0;
        end else if (clock_restart_event) begin
            pending_next = 1'h1;
        end else if (delivered) begin
            pending_next = 1'h0;
        end
    end

    // pending latch register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pending_reg <= 1'h0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // consecutive high sampling
    ////////////////////////////////////////////////////////////////////////////

    // count clock edges with the line high, restart on low
    always_comb begin
        high_cnt_next = high_cnt_reg;
        if (!line_sync) begin
            high_cnt_next = CCR_CNT_ZERO;
        end else if (pci_edge && high_cnt_reg != CCR_HIGH_MIN) begin
            high_cnt_next = high_cnt_reg + CCR_CNT_ONE;
        end
    end

    // high counter register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            high_cnt_reg <= CCR_CNT_ZERO;
        end else begin
            high_cnt_reg <= high_cnt_next;
        end
    end

    // line stopped and stable long enough
    assign high_ok = line_sync && (high_cnt_reg == CCR_HIGH_MIN);

    ////////////////////////////////////////////////////////////////////////////
    // request sequencer
    ////////////////////////////////////////////////////////////////////////////

    // begin a pull-low when something pending and the clock is stopped
    assign start_drive = irq_clock_run_enable_i && pending_reg && high_ok;
    // second rising clock edge while holding ends the pull
    assign drive_done = pci_edge && (hold_cnt_reg == CCR_HOLD_EDGES - CCR_CNT_ONE);

    // next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CCR_ST_IDLE: begin
                if (start_drive) begin
                    state_next = CCR_ST_DRIVE;
                end
            end
            CCR_ST_DRIVE: begin
                if (!irq_clock_run_enable_i || drive_done) begin
                    state_next = CCR_ST_IDLE;
                end
            end
            default: begin
                state_next = CCR_ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_reg <= CCR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // count clock edges seen while holding the line low
    always_comb begin
        hold_cnt_next = hold_cnt_reg;
        if (state_next != CCR_ST_DRIVE) begin
            hold_cnt_next = CCR_CNT_ZERO;
        end else if (state_reg == CCR_ST_DRIVE && pci_edge) begin
            hold_cnt_next = hold_cnt_reg + CCR_CNT_ONE;
        end
    end

    // hold counter register
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            hold_cnt_reg <= CCR_CNT_ZERO;
        end else begin
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // open-drain driver and status
    ////////////////////////////////////////////////////////////////////////////

    // enable follows the next state so the pull starts with the request
    assign oe_next = (state_next == CCR_ST_DRIVE) && irq_clock_run_enable_i;

    // driver registers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            oe_reg <= 1'h0;
            drive_level_reg <= CCR_LINE_LOW;
        end else begin
            oe_reg <= oe_next;
            drive_level_reg <= CCR_LINE_LOW;
        end
    end

    // event strobe for observers
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            event_reg <= 1'h0;
        end else begin
            event_reg <= clock_restart_event;
        end
    end

    // outputs
    assign clkrun_n_o = drive_level_reg;
    assign clkrun_n_oe_o = oe_reg;
    assign clock_restart_event_o = event_reg;
    assign restart_pending_o = pending_reg;
    assign line_stopped_o = line_sync;

endmodule : ccr_clock_run_request

`default_nettype wire

// File: hdl/ccr_pkg.sv
// shared constants and types for the clock run request block
`default_nettype none

package ccr_pkg;

    // number of internal interrupt lines routed to the serial irq block
    localparam int unsigned CCR_IRQ_W = 16;
    // number of internal dma request lines
    localparam int unsigned CCR_DRQ_W = 4;

    // width of the edge counters
    localparam int unsigned CCR_CNT_W = 2;
    // sampled-high clock edges required before the line may be pulled low
    localparam logic [CCR_CNT_W-1:0] CCR_HIGH_MIN = 2'h2;
    // clock rising edges the line is held low once pulled
    localparam logic [CCR_CNT_W-1:0] CCR_HOLD_EDGES = 2'h2;
    // counter reset value
    localparam logic [CCR_CNT_W-1:0] CCR_CNT_ZERO = 2'h0;
    // counter increment
    localparam logic [CCR_CNT_W-1:0] CCR_CNT_ONE = 2'h1;

    // level driven onto the open-drain line while enabled
    localparam logic CCR_LINE_LOW = 1'h0;
    // reset value of the synchronised line (pulled up, idle high)
    localparam logic CCR_LINE_IDLE = 1'h1;

    // internal sources that may ask for the clock
    typedef struct packed {
        logic [CCR_IRQ_W-1:0] irq;
        logic [CCR_DRQ_W-1:0] drq;
    } ccr_src_t;

    // completion strobes from the host-side transfer logic
    typedef struct packed {
        logic sirq_done;
        logic dma_done;
    } ccr_done_t;

    // request sequencer states
    typedef enum logic [1:0] {
        CCR_ST_IDLE  = 2'b00,
        CCR_ST_DRIVE = 2'b01
    } ccr_state_t;

endpackage : ccr_pkg

`default_nettype wire

// File: hdl/ccr_sync.sv
// two-stage synchroniser with a rising-edge pulse on the synchronised side
`timescale 1ns/10ps
`default_nettype none

module ccr_sync (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // asynchronous level in
    input wire logic async_i,
    // synchronised level and its rising edge
    output logic sync_o,
    output logic rise_o
);
    import ccr_pkg::*;

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_reg <= CCR_LINE_IDLE;
            sync_reg <= CCR_LINE_IDLE;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    // previous synchronised value for edge detection
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            last_reg <= CCR_LINE_IDLE;
        end else begin
            last_reg <= sync_reg;
        end
    end

    // outputs
    assign sync_o = sync_reg;
    assign rise_o = sync_reg & ~last_reg;

endmodule : ccr_sync

`default_nettype wire

// File: sim/ccr_chk.sv
// concurrent checks on the clock run request ports
`timescale 1ns/10ps
`default_nettype none

module ccr_chk (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic irq_clock_run_enable_i,
    input wire ccr_pkg::ccr_src_t src_i,
    input wire ccr_pkg::ccr_done_t done_i,
    input wire logic pci_clk_i,
    input wire logic clkrun_n_i,
    // watched outputs
    input wire logic clkrun_n_o,
    input wire logic clkrun_n_oe_o,
    input wire logic clock_restart_event_o,
    input wire logic restart_pending_o,
    input wire logic line_stopped_o
);
    import ccr_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // source edge seen while enabled, and start of a pull
    sequence s_evt;
        irq_clock_run_enable_i && (src_i.irq != $past(src_i.irq)
            || (src_i.drq & ~$past(src_i.drq)) != '0);
    endsequence
    sequence s_pull;
        $rose(clkrun_n_oe_o);
    endsequence
    chk_evt_pulse: assert property (s_evt |=> clock_restart_event_o)
        else $error("restart event pulse missing");
    chk_dis_event: assert property (!irq_clock_run_enable_i |=> !clock_restart_event_o)
        else $error("event reported while disabled");
    chk_dis_drive: assert property (!irq_clock_run_enable_i |=> !clkrun_n_oe_o && !restart_pending_o)
        else $error("line driven or pending while disabled");
    chk_evt_pend: assert property (clock_restart_event_o |-> restart_pending_o)
        else $error("event not pending");
    chk_pend_hold: assert property (restart_pending_o && done_i == '0 && irq_clock_run_enable_i
        |=> restart_pending_o)
        else $error("pending dropped without delivery");
    chk_pend_clear: assert property (done_i != '0 && $stable(src_i) |=> !restart_pending_o)
        else $error("pending kept after delivery");
    chk_pull_cause: assert property (s_pull |-> $past(line_stopped_o) && $past(restart_pending_o))
        else $error("pull without stopped line and pending event");
    chk_low_idle: assert property (!line_stopped_o && !clkrun_n_oe_o |=> !clkrun_n_oe_o)
        else $error("pull while line already low");
    chk_pull_len: assert property (s_pull |-> clkrun_n_oe_o[*4])
        else $error("pull released too early");
    chk_pull_end: assert property (s_pull |-> ##[4:60] !clkrun_n_oe_o)
        else $error("pull never released");
    chk_drive_low: assert property (clkrun_n_oe_o |-> clkrun_n_o == CCR_LINE_LOW)
        else $error("driven level not low");
endmodule : ccr_chk

bind ccr_clock_run_request ccr_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .irq_clock_run_enable_i(irq_clock_run_enable_i), .src_i(src_i), .done_i(done_i),
    .pci_clk_i(pci_clk_i), .clkrun_n_i(clkrun_n_i), .clkrun_n_o(clkrun_n_o),
    .clkrun_n_oe_o(clkrun_n_oe_o), .clock_restart_event_o(clock_restart_event_o),
    .restart_pending_o(restart_pending_o), .line_stopped_o(line_stopped_o));

`default_nettype wire

// File: sim/ccr_gen_model.sv
// behavioural bus clock generator sharing the clock run line
`timescale 1ns/10ps
`default_nettype none

module ccr_gen_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // line level and test controls
    input wire logic line_i,
    input wire logic run_i,
    input wire logic slow_i,
    // bus clock, line pull and burst status
    output logic pci_clk_o,
    output logic gen_oe_o,
    output logic busy_o
);
    int ticks;
    int d;
    assign d = slow_i ? 12 : 0;
    // burst on a request seen on the line, parked while run_i holds it
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_o <= 1'b1;
            ticks <= 0;
        end else if (busy_o) begin
            ticks <= (run_i && ticks >= d + 8) ? ticks : ticks + 1;
            busy_o <= run_i || ticks < d + 40;
        end else if (!line_i || run_i) begin
            busy_o <= 1'b1;
            ticks <= 0;
        end
    end
    // clock only inside a burst, line held low while running
    assign pci_clk_o = busy_o && ticks >= d && ((ticks - d) & 2) != 0;
    assign gen_oe_o = busy_o && (run_i || (ticks >= d + 4 && ticks < d + 24));
endmodule : ccr_gen_model

`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the clock run request block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import ccr_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic en = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    ccr_src_t src = '0;
    ccr_done_t done = '0;
    logic pci_clk, gen_oe, busy, drv, oe, evt, pend, stp, line;
    int err_count = 0;
    int samples_checked = 0;
    // clock and wired line with pull-up
    always #50 clk_sys_i = ~clk_sys_i;
    assign line = (oe ? drv : 1'b1) & ~gen_oe;
    ccr_clock_run_request uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .irq_clock_run_enable_i(en), .src_i(src), .done_i(done), .pci_clk_i(pci_clk),
        .clkrun_n_i(line), .clkrun_n_o(drv), .clkrun_n_oe_o(oe),
        .clock_restart_event_o(evt), .restart_pending_o(pend), .line_stopped_o(stp));
    ccr_gen_model gen (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .line_i(line), .run_i(run),
        .slow_i(slow), .pci_clk_o(pci_clk), .gen_oe_o(gen_oe), .busy_o(busy));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns: expected %b got %b", $time, exp, got);
        end
    endtask : chk
    task automatic wait_oe(input logic v, input int n);
        for (int i = 0; i < n && oe !== v; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        chk(v, oe);
    endtask : wait_oe
    task automatic wait_idle;
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge clk_sys_i);
        repeat (4) @(negedge clk_sys_i);
    endtask : wait_idle
    task automatic fire(input ccr_src_t s, input logic exp);
        @(negedge clk_sys_i);
        src = s;
        @(posedge clk_sys_i);
        #1;
        chk(exp, evt);
    endtask : fire
    task automatic deliver(input logic sirq);
        @(negedge clk_sys_i);
        done = ccr_done_t'({sirq, ~sirq});
        @(negedge clk_sys_i);
        done = '0;
        chk(1'b0, pend);
    endtask : deliver
    // interrupt rise on a stopped clock
    task automatic t_irq;
        ccr_src_t s;
        s = src;
        s.irq[5] = 1'b1;
        fire(s, 1'b1);
        chk(1'b1, pend);
        wait_oe(1'b1, 4);
        chk(1'b0, line);
        wait_oe(1'b0, 60);
        chk(1'b1, pend);
        deliver(1'b1);
        wait_idle;
        chk(1'b0, oe);
        $display("t_irq done");
    endtask : t_irq
    // dma request, slow generator, pull repeated until delivery
    task automatic t_rearm;
        ccr_src_t s;
        slow = 1'b1;
        s = src;
        s.drq[2] = 1'b1;
        fire(s, 1'b1);
        wait_oe(1'b1, 4);
        wait_oe(1'b0, 80);
        wait_oe(1'b1, 120);
        wait_oe(1'b0, 80);
        deliver(1'b0);
        wait_idle;
        chk(1'b0, oe);
        s.drq[2] = 1'b0;
        fire(s, 1'b0);
        slow = 1'b0;
        $display("t_rearm done");
    endtask : t_rearm
    // event while the generator keeps the clock running
    task automatic t_running;
        ccr_src_t s;
        @(negedge clk_sys_i);
        run = 1'b1;
        s = src;
        s.irq[5] = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        fire(s, 1'b1);
        repeat (20) @(negedge clk_sys_i);
        chk(1'b0, oe);
        chk(1'b1, pend);
        run = 1'b0;
        wait_oe(1'b1, 80);
        wait_oe(1'b0, 80);
        deliver(1'b1);
        wait_idle;
        $display("t_running done");
    endtask : t_running
    // enable low blocks events and drops the pending request
    task automatic t_disable;
        ccr_src_t s;
        s = src;
        @(negedge clk_sys_i);
        run = 1'b1;
        en = 1'b0;
        s.irq[0] = ~s.irq[0];
        fire(s, 1'b0);
        chk(1'b0, pend);
        @(negedge clk_sys_i);
        en = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        s.irq[0] = ~s.irq[0];
        fire(s, 1'b1);
        @(negedge clk_sys_i);
        en = 1'b0;
        @(negedge clk_sys_i);
        chk(1'b0, pend);
        en = 1'b1;
        run = 1'b0;
        wait_idle;
        chk(1'b0, oe);
        $display("t_disable done");
    endtask : t_disable
    // main sequence
    initial begin
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        en = 1'b1;
        wait_idle;
        chk(1'b1, stp);
        t_irq;
        t_rearm;
        t_running;
        t_disable;
        stop_test;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        err_count++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        stop_test;
    end
endmodule : tb_top

`default_nettype wire
